/* display_8080_bus_master_tb.sv */
// Self-checking bench for the display bus master
`timescale 1ns/1ps
`default_nettype none
module display_8080_bus_master_tb;
    logic clk = 1'b0, rst_n = 1'b0, prst = 1'b0, vld = 1'b0, rdq = 1'b0;
    logic rsq = 1'b0, rdy, rdv, cs_n, rs, rd_n, wr_n, res_n, oe, rs_seen;
    logic [7:0] dq = 8'h00, rdd, dev_o, mdl_o, seen, bus;
    int fail_count = 0, comparisons = 0;
    assign bus = oe ? dev_o : mdl_o;
    dpm_master dpm_master_i (.sys_clk_i(clk), .rst_n_i(rst_n),
        .panel_reset_req_i(prst), .req_valid_i(vld), .req_read_i(rdq),
        .req_rs_i(rsq), .req_data_i(dq), .req_ready_o(rdy), .rd_valid_o(rdv),
        .rd_data_o(rdd), .panel_cs_n_o(cs_n), .register_select_line_o(rs),
        .panel_rd_n_o(rd_n), .panel_wr_n_o(wr_n), .panel_reset_n_o(res_n),
        .panel_data_bus_i(bus), .panel_data_bus_o(dev_o),
        .panel_data_bus_oe_o(oe));
    dpm_panel_model dpm_panel_model_i (.cs_n_i(cs_n), .rs_i(rs), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .bus_i(bus), .bus_o(mdl_o), .byte_o(seen),
        .rs_seen_o(rs_seen));
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        comparisons++;
        if (s !== e)
        begin
            fail_count++;
            $display("Error at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic give_verdict;
        $display("Mismatches %0d in %0d checks", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait: 0 ready, 1 read data, 2 panel reset low
    task automatic wt(input int k);
        for (int n = 0; n < 1000; n++)
        begin
            @(posedge clk) #1;
            if ((k == 0 && rdy === 1'b1) || (k == 1 && rdv === 1'b1)
                || (k == 2 && res_n === 1'b0)) return;
        end
        fail_count++;
        give_verdict;
    endtask
    task automatic req(input logic p, r, s, input logic [7:0] d);
        wt(0);
        {prst, vld, rdq, rsq, dq} = {p, !p, r, s, d};
        @(posedge clk) #1;
        {prst, vld} = 2'h0;
    endtask
    task automatic t_write;
        req(1'b0, 1'b0, 1'b0, 8'hA5);
        req(1'b0, 1'b0, 1'b1, 8'h5A);
        chk({1'b0, seen}, 9'h0A5);
        chk({8'h00, rs_seen}, 9'h000);
        wt(0);
        chk({1'b0, seen}, 9'h05A);
        chk({8'h00, rs_seen}, 9'h001);
    endtask
    task automatic t_read;
        req(1'b0, 1'b1, 1'b0, 8'h00);
        wt(1);
        chk({1'b0, rdd}, 9'h03C);
        req(1'b0, 1'b1, 1'b1, 8'h00);
        wt(1);
        chk({1'b0, rdd}, 9'h05A);
    endtask
    task automatic t_reset;
        int n;
        req(1'b1, 1'b0, 1'b0, 8'h00);
        chk({8'h00, res_n}, 9'h000);
        for (n = 0; n < 1000 && res_n === 1'b0; n++) @(posedge clk) #1;
        chk(n[8:0], 9'h190);
    endtask
    task automatic t_mreset;
        req(1'b0, 1'b0, 1'b0, 8'hC3);
        repeat (5) @(posedge clk) #1;
        rst_n = 1'b0;
        repeat (20) @(posedge clk) #1;
        chk({5'h00, cs_n, wr_n, oe, rdy}, 9'h00C);
        rst_n = 1'b1;
        wt(0);
        chk({1'b0, seen}, 9'h05A);
    endtask
    initial forever #2.5 clk = ~clk;
    initial
    begin
        repeat (20) @(posedge clk) #1;
        rst_n = 1'b1;
        t_write;
        t_read;
        t_mreset;
        t_reset;
        give_verdict;
    end
endmodule
`default_nettype wire

/* dpm_defines.vh */
// Constants for the display parallel bus master
`ifndef DPM_DEFINES_VH
`define DPM_DEFINES_VH

`define DPM_CLK_MHZ          200
`define DPM_WR_LOW_NS        170
`define DPM_WR_HIGH_NS       85
`define DPM_WR_SETUP_NS      85
`define DPM_RD_LOW_NS        300
`define DPM_RD_HIGH_NS       300
`define DPM_RST_LOW_NS       2000
// Least times rounded up to whole 5 ns cycles, sized to the counter
`define DPM_CNT_W            9
`define DPM_WR_LOW_CYC       9'h022
`define DPM_WR_HIGH_CYC      9'h011
`define DPM_WR_SETUP_CYC     9'h011
`define DPM_RD_LOW_CYC       9'h03C
`define DPM_RD_HIGH_CYC      9'h03C
`define DPM_RST_LOW_CYC      9'h190

`endif

/* dpm_master.v */
// Display 8-bit parallel bus master
`timescale 1ns/1ps
`default_nettype none
`include "dpm_defines.vh"

module dpm_master
(
    input  wire       sys_clk_i,
    input  wire       rst_n_i,
    input  wire       panel_reset_req_i,
    input  wire       req_valid_i,
    input  wire       req_read_i,
    input  wire       req_rs_i,
    input  wire [7:0] req_data_i,
    output reg        req_ready_o,
    output reg        rd_valid_o,
    output reg  [7:0] rd_data_o,
    output reg        panel_cs_n_o,
    output reg        register_select_line_o,
    output reg        panel_rd_n_o,
    output reg        panel_wr_n_o,
    output reg        panel_reset_n_o,
    input  wire [7:0] panel_data_bus_i,
    output reg  [7:0] panel_data_bus_o,
    output reg        panel_data_bus_oe_o
);

////////////////////////////////////////////////////////////////////////////////

localparam [2:0] ST_IDLE  = 3'd0;
localparam [2:0] ST_SETUP = 3'd1;
localparam [2:0] ST_WLOW  = 3'd2;
localparam [2:0] ST_RLOW  = 3'd3;
localparam [2:0] ST_HIGH  = 3'd4;
localparam [2:0] ST_RST   = 3'd5;

localparam [`DPM_CNT_W-1:0] WR_SETUP = `DPM_WR_SETUP_CYC;
localparam [`DPM_CNT_W-1:0] WR_LOW   = `DPM_WR_LOW_CYC;
localparam [`DPM_CNT_W-1:0] WR_HIGH  = `DPM_WR_HIGH_CYC;
localparam [`DPM_CNT_W-1:0] RD_LOW   = `DPM_RD_LOW_CYC;
localparam [`DPM_CNT_W-1:0] RD_HIGH  = `DPM_RD_HIGH_CYC;
localparam [`DPM_CNT_W-1:0] RST_LOW  = `DPM_RST_LOW_CYC;
localparam [`DPM_CNT_W-1:0] ONE      = 9'h001;

reg [2:0]            state_q;
reg [2:0]            state_d;
reg [`DPM_CNT_W-1:0] cnt_q;
reg [`DPM_CNT_W-1:0] cnt_d;
reg                  ready_d;
reg                  rd_valid_d;
reg [7:0]            rd_data_d;
reg                  cs_n_d;
reg                  rs_d;
reg                  rd_n_d;
reg                  wr_n_d;
reg                  reset_n_d;
reg [7:0]            dout_d;
reg                  oe_d;
wire                 cnt_done;
wire                 take_req;

////////////////////////////////////////////////////////////////////////////////

// Phase counters end on one, so a count of N lasts N cycles
assign cnt_done = (cnt_q == ONE);
assign take_req = req_valid_i && req_ready_o;

////////////////////////////////////////////////////////////////////////////////

// Phase sequencing
always @*
begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
    ST_IDLE:
    begin
        // Panel reset wins over a pending access
        if (panel_reset_req_i)
        begin
            cnt_d   = RST_LOW;
            state_d = ST_RST;
        end
        else if (take_req)
        begin
            if (req_read_i)
            begin
                cnt_d   = RD_LOW;
                state_d = ST_RLOW;
            end
            else
            begin
                cnt_d   = WR_SETUP;
                state_d = ST_SETUP;
            end
        end
    end
    ST_SETUP:
    begin
        if (cnt_done)
        begin
            cnt_d   = WR_LOW;
            state_d = ST_WLOW;
        end
        else
            cnt_d = cnt_q - ONE;
    end
    ST_WLOW:
    begin
        if (cnt_done)
        begin
            cnt_d   = WR_HIGH;
            state_d = ST_HIGH;
        end
        else
            cnt_d = cnt_q - ONE;
    end
    ST_RLOW:
    begin
        if (cnt_done)
        begin
            cnt_d   = RD_HIGH;
            state_d = ST_HIGH;
        end
        else
            cnt_d = cnt_q - ONE;
    end
    ST_HIGH:
    begin
        if (cnt_done)
            state_d = ST_IDLE;
        else
            cnt_d = cnt_q - ONE;
    end
    ST_RST:
    begin
        if (cnt_done)
            state_d = ST_IDLE;
        else
            cnt_d = cnt_q - ONE;
    end
    default:
        state_d = ST_IDLE;
    endcase
end

////////////////////////////////////////////////////////////////////////////////

// Pin and handshake values; all of them land in flops
always @*
begin
    ready_d    = req_ready_o;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_o;
    cs_n_d     = panel_cs_n_o;
    rs_d       = register_select_line_o;
    rd_n_d     = panel_rd_n_o;
    wr_n_d     = panel_wr_n_o;
    reset_n_d  = panel_reset_n_o;
    dout_d     = panel_data_bus_o;
    oe_d       = panel_data_bus_oe_o;
    case (state_q)
    ST_IDLE:
    begin
        cs_n_d  = 1'b1;
        oe_d    = 1'b0;
        ready_d = 1'b1;
        // Ready dropped once a request is taken
        if (panel_reset_req_i)
        begin
            ready_d   = 1'b0;
            reset_n_d = 1'b0;
        end
        else if (take_req)
        begin
            ready_d = 1'b0;
            cs_n_d  = 1'b0;
            rs_d    = req_rs_i;
            if (req_read_i)
                rd_n_d = 1'b0;
            else
            begin
                // Data set up ahead of the strobe
                dout_d = req_data_i;
                oe_d   = 1'b1;
            end
        end
    end
    ST_SETUP:
    begin
        if (cnt_done)
            wr_n_d = 1'b0;
    end
    ST_WLOW:
    begin
        // Bus held through the rising edge
        if (cnt_done)
            wr_n_d = 1'b1;
    end
    ST_RLOW:
    begin
        if (cnt_done)
        begin
            // Sampled at the end of the low phase
            rd_data_d  = panel_data_bus_i;
            rd_valid_d = 1'b1;
            rd_n_d     = 1'b1;
        end
    end
    ST_HIGH:
    begin
        // Select released at once; high time is still honoured
        cs_n_d = 1'b1;
        oe_d   = 1'b0;
        if (cnt_done)
            ready_d = 1'b1;
    end
    ST_RST:
    begin
        if (cnt_done)
        begin
            reset_n_d = 1'b1;
            ready_d   = 1'b1;
        end
    end
    default:
        cs_n_d = 1'b1;
    endcase
end

////////////////////////////////////////////////////////////////////////////////

// Reset comes from the master reset pin, synchronous
always @(posedge sys_clk_i)
begin
    if (!rst_n_i)
    begin
        state_q <= ST_IDLE;
        cnt_q   <= 9'h000;
    end
    else
    begin
        state_q <= state_d;
        cnt_q   <= cnt_d;
    end
end

// Strobes, select and panel reset straight from flops
always @(posedge sys_clk_i)
begin
    if (!rst_n_i)
    begin
        panel_cs_n_o           <= 1'b1;
        register_select_line_o <= 1'b0;
        panel_rd_n_o           <= 1'b1;
        panel_wr_n_o           <= 1'b1;
        panel_reset_n_o        <= 1'b1;
    end
    else
    begin
        panel_cs_n_o           <= cs_n_d;
        register_select_line_o <= rs_d;
        panel_rd_n_o           <= rd_n_d;
        panel_wr_n_o           <= wr_n_d;
        panel_reset_n_o        <= reset_n_d;
    end
end

// Data path and handshake straight from flops
always @(posedge sys_clk_i)
begin
    if (!rst_n_i)
    begin
        req_ready_o            <= 1'b0;
        rd_valid_o             <= 1'b0;
        rd_data_o              <= 8'h00;
        panel_data_bus_o       <= 8'h00;
        panel_data_bus_oe_o    <= 1'b0;
    end
    else
    begin
        req_ready_o            <= ready_d;
        rd_valid_o             <= rd_valid_d;
        rd_data_o              <= rd_data_d;
        panel_data_bus_o       <= dout_d;
        panel_data_bus_oe_o    <= oe_d;
    end
end

endmodule
`default_nettype wire

/* dpm_master_checker.sv */
// Pin timing checks for the display bus master
`timescale 1ns/1ps
`default_nettype none
module dpm_master_checker
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic rd_valid_o,
    input wire logic panel_cs_n_o,
    input wire logic panel_rd_n_o,
    input wire logic panel_wr_n_o,
    input wire logic panel_reset_n_o,
    input wire logic panel_data_bus_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wr_sel_a: assert property (!panel_wr_n_o |-> !panel_cs_n_o)
        else $error("Write strobe without select");
    wr_drive_a: assert property (!panel_wr_n_o |-> panel_data_bus_oe_o)
        else $error("Write strobe with bus released");
    rd_sel_a: assert property (!panel_rd_n_o |-> !panel_cs_n_o)
        else $error("Read strobe without select");
    rd_float_a: assert property (!panel_rd_n_o |-> !panel_data_bus_oe_o)
        else $error("Bus driven during read");
    wr_low_a: assert property ($fell(panel_wr_n_o) |->
        ##33 !panel_wr_n_o ##1 panel_wr_n_o) else $error("Write low length");
    wr_setup_a: assert property ($fell(panel_wr_n_o) |->
        $past(panel_data_bus_oe_o, 17)) else $error("Write setup short");
    rd_low_a: assert property ($fell(panel_rd_n_o) |->
        ##59 !panel_rd_n_o ##1 panel_rd_n_o) else $error("Read low length");
    rd_done_a: assert property (rd_valid_o |-> $rose(panel_rd_n_o))
        else $error("Read data without strobe end");
    rst_low_a: assert property ($fell(panel_reset_n_o) |->
        ##[399:399] !panel_reset_n_o ##1 panel_reset_n_o)
        else $error("Panel reset length");
    cover property ($fell(panel_wr_n_o));
    cover property (rd_valid_o);
    cover property ($rose(panel_reset_n_o));
endmodule
bind dpm_master dpm_master_checker dpm_master_checker_i (.sys_clk_i,
    .rst_n_i, .rd_valid_o, .panel_cs_n_o, .panel_rd_n_o, .panel_wr_n_o,
    .panel_reset_n_o, .panel_data_bus_oe_o);
`default_nettype wire

/* dpm_panel_model.sv */
// Behavioural display controller on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module dpm_panel_model
(
    input  wire logic       cs_n_i,
    input  wire logic       rs_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic [7:0] bus_i,
    output var  logic [7:0] bus_o,
    output var  logic [7:0] byte_o,
    output var  logic       rs_seen_o
);
    // Released bus shows the inverse, so a late sample cannot match
    logic [7:0] last_q = 8'h00;
    logic       hold_q = 1'b0;
    always @*
        bus_o = ((!cs_n_i && !rd_n_i) || hold_q) ? (rs_i ? byte_o : 8'h3C)
            : ~last_q;
    // Read data kept for the hold time after the strobe rises
    always @(posedge rd_n_i)
        if (!cs_n_i)
        begin
            hold_q = 1'b1;
            last_q = rs_i ? byte_o : 8'h3C;
            #150;
            hold_q = 1'b0;
        end
    always @(posedge wr_n_i)
        if (!cs_n_i)
        begin
            byte_o <= bus_i;
            rs_seen_o <= rs_i;
        end
endmodule
`default_nettype wire
